// ---- rtl/superio_pin_mux_pkg.sv ----
package superio_pin_mux_pkg;

  // configuration index space locations
  localparam logic [7:0] CFG_A_INDEX = 8'h23;
  localparam logic [7:0] CFG_B_INDEX = 8'h24;

  // values after reset and writable bits (reserved bits stay zero, strap is read-only)
  localparam logic [7:0] CFG_A_RESET = 8'h00;
  localparam logic [7:0] CFG_B_RESET = 8'h00;
  localparam logic [7:0] CFG_A_WMASK = 8'hE7;
  localparam logic [7:0] CFG_B_WMASK = 8'hD0;
  localparam logic [7:0] READ_UNMAPPED = 8'h00;

  // serial/infrared pin bank: slot k is a function signal, value is the bank pin index
  // bank pins 0..9 are package pins 118,119,120,121,122,124,125,126,127,128
  localparam int unsigned SER_PIN_COUNT = 10;
  localparam logic [3:0] SER_IR_FIRST = 4'h8;
  localparam logic [9:0][3:0] SER_PIN_STD = {4'h9, 4'h8, 4'h7, 4'h6, 4'h5, 4'h4, 4'h3, 4'h2,
                                             4'h1, 4'h0};
  localparam logic [9:0][3:0] SER_PIN_LEGACY = {4'h0, 4'h2, 4'h9, 4'h8, 4'h7, 4'h6, 4'h5,
                                                4'h4, 4'h3, 4'h1};
  // slots that the serial function drives (transmit, request, terminal ready, ir transmit)
  localparam logic [9:0] SER_DIR_OUT = 10'h254;

  // port line that takes each slot when the function is not routed (8 and 9 = output-only)
  localparam logic [3:0] LINE_GPO12 = 4'h8;
  localparam logic [3:0] LINE_GPO13 = 4'h9;
  localparam logic [9:0][3:0] SLOT_LINE_STD = {4'h7, 4'h6, 4'h2, 4'h0, 4'h5, 4'h9, 4'h4,
                                               4'h8, 4'h3, 4'h1};
  localparam logic [9:0][3:0] SLOT_LINE_LEGACY = {4'h0, 4'h2, 4'h7, 4'h6, 4'h5, 4'h9, 4'h4,
                                                  4'h8, 4'h3, 4'h1};

  // port lines shared with the fan pulse pins (a, b, c) and the sensor wire pin
  localparam logic [2:0][2:0] FAN_LINE = {3'h5, 3'h4, 3'h3};
  localparam logic [2:0] SENSOR_LINE = 3'h0;

  typedef struct packed {
    logic out;
    logic oe;
  } pin_drive_t;

  typedef struct packed {
    logic fan_pulse3_route;
    logic fan_pulse2_route;
    logic fan_pulse1_route;
    logic [1:0] reserved;
    logic legacy_pinout_select;
    logic second_serial_route;
    logic infrared_route;
  } cfg_a_t;

  typedef struct packed {
    logic sensor_wire_route_n;
    logic tach_pin_enable;
    logic reserved5;
    logic pci_reset_out_b_route_n;
    logic [2:0] reserved;
    logic main_supply_strap_b;
  } cfg_b_t;

  typedef struct packed {
    logic serial_tx;
    logic request_to_send;
    logic terminal_ready;
    logic infrared_transmit;
  } ser_tx_t;

  typedef struct packed {
    logic ring_indicate;
    logic serial_rx;
    logic set_ready;
    logic clear_to_send;
    logic carrier_detect;
    logic infrared_receive;
  } ser_rx_t;

  typedef struct packed {
    cfg_a_t cfg_a;
    cfg_b_t cfg_b;
    logic [7:0] rdata;
    logic rvalid;
    logic supply_good_q;
  } state_t;

  localparam state_t STATE_RESET = '{cfg_a: cfg_a_t'(CFG_A_RESET), cfg_b: cfg_b_t'(CFG_B_RESET),
                                     rdata: 8'h00, rvalid: 1'b0, supply_good_q: 1'b0};

endpackage

// ---- rtl/pin_route_cell.sv ----
`timescale 1ns/1ns
`default_nettype none

// one shared pin: port line when sel is low, alternate function when high
module pin_route_cell (
  // selection
  input wire logic sel,
  // the two candidate drivers
  input wire superio_pin_mux_pkg::pin_drive_t port_drive,
  input wire superio_pin_mux_pkg::pin_drive_t func_drive,
  // pad side
  output var superio_pin_mux_pkg::pin_drive_t pad_drive,
  input wire logic pad_in,
  // pad level returned to whichever owner holds the pin, zero to the other
  output logic port_in,
  output logic func_in
);

  // the idle owner sees a quiet zero so it cannot react to foreign traffic
  assign pad_drive = sel ? func_drive : port_drive;
  assign port_in = pad_in & ~sel;
  assign func_in = pad_in & sel;

endmodule // pin_route_cell

`default_nettype wire

// ---- rtl/superio_pin_function_mux.sv ----
`timescale 1ns/1ns
`default_nettype none

module superio_pin_function_mux (
  // clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // configuration index port
  input wire logic [7:0] cfg_index,
  input wire logic [7:0] cfg_wdata,
  input wire logic cfg_wr,
  input wire logic cfg_rd,
  output logic [7:0] cfg_rdata,
  output logic cfg_rvalid,
  // main supply and strap
  input wire logic main_supply_good,
  input wire logic main_supply_strap_b,
  output logic tach_pin_enable,
  // alternate functions
  input wire logic [2:0] fan_pulse_out,
  input wire superio_pin_mux_pkg::pin_drive_t sensor_wire_drive,
  output logic sensor_wire_in,
  input wire logic pci_reset_out_b,
  input wire superio_pin_mux_pkg::ser_tx_t ser_tx,
  output var superio_pin_mux_pkg::ser_rx_t ser_rx,
  // general-purpose port side
  input wire logic [7:0] port_e_out,
  input wire logic [7:0] port_e_oe,
  output logic [7:0] port_e_in,
  input wire logic gpo12,
  input wire logic gpo13,
  input wire superio_pin_mux_pkg::pin_drive_t port_e_line_12,
  output logic port_e_line_12_in,
  // pads
  output var superio_pin_mux_pkg::pin_drive_t [2:0] fan_pin,
  input wire logic [2:0] fan_pin_in,
  output var superio_pin_mux_pkg::pin_drive_t sensor_pin,
  input wire logic sensor_pin_in,
  output var superio_pin_mux_pkg::pin_drive_t pci_reset_pin,
  input wire logic pci_reset_pin_in,
  output var superio_pin_mux_pkg::pin_drive_t [9:0] ser_pin,
  input wire logic [9:0] ser_pin_in
);

  superio_pin_mux_pkg::state_t st;
  superio_pin_mux_pkg::state_t next_st;
  logic [2:0] fan_sel;
  logic [2:0] fan_port_in;
  logic sensor_port_in;
  logic [9:0] slot_func_en;
  logic [9:0][3:0] slot_pin;
  logic [9:0][3:0] slot_line;
  superio_pin_mux_pkg::pin_drive_t [9:0] slot_port;
  superio_pin_mux_pkg::pin_drive_t [9:0] slot_func;
  logic [9:0] bank_sel;
  superio_pin_mux_pkg::pin_drive_t [9:0] bank_port;
  superio_pin_mux_pkg::pin_drive_t [9:0] bank_func;
  logic [9:0] bank_port_in;
  logic [9:0] bank_func_in;
  logic [9:0] slot_port_in;
  logic [9:0] slot_func_in;
  logic [9:0] ser_fn_out;

  // register read view; reserved bits are held at zero so they read as zero
  function automatic logic [7:0] read_value(input logic [7:0] index,
                                            input superio_pin_mux_pkg::state_t s);
    logic [7:0] v;
    v = superio_pin_mux_pkg::READ_UNMAPPED;
    if (index == superio_pin_mux_pkg::CFG_A_INDEX) begin
      v = s.cfg_a;
    end else if (index == superio_pin_mux_pkg::CFG_B_INDEX) begin
      v = s.cfg_b;
    end
    return v;
  endfunction

  // register next state: writes, read capture and strap capture
  always_comb begin
    next_st = st;
    next_st.rvalid = cfg_rd;
    next_st.supply_good_q = main_supply_good;
    if (cfg_rd) begin
      next_st.rdata = read_value(cfg_index, st); // same-cycle write is seen on the next read
    end
    if (cfg_wr && cfg_index == superio_pin_mux_pkg::CFG_A_INDEX) begin
      next_st.cfg_a = (cfg_wdata & superio_pin_mux_pkg::CFG_A_WMASK) |
                      (st.cfg_a & ~superio_pin_mux_pkg::CFG_A_WMASK);
    end
    if (cfg_wr && cfg_index == superio_pin_mux_pkg::CFG_B_INDEX) begin
      next_st.cfg_b = (cfg_wdata & superio_pin_mux_pkg::CFG_B_WMASK) |
                      (st.cfg_b & ~superio_pin_mux_pkg::CFG_B_WMASK);
    end
    // strap is caught on each rising edge of main supply good
    if (main_supply_good && !st.supply_good_q) begin
      next_st.cfg_b.main_supply_strap_b = main_supply_strap_b;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      st <= superio_pin_mux_pkg::STATE_RESET;
    end else begin
      st <= next_st;
    end
  end

  assign cfg_rdata = st.rdata;
  assign cfg_rvalid = st.rvalid;
  assign tach_pin_enable = st.cfg_b.tach_pin_enable;

  // fan pulse pins, index 0..2 = a..c
  assign fan_sel = {st.cfg_a.fan_pulse3_route, st.cfg_a.fan_pulse2_route,
                    st.cfg_a.fan_pulse1_route};

  for (genvar f = 0; f < 3; f++) begin : g_fan
    pin_route_cell u_fan (
      .sel(fan_sel[f]),
      .port_drive({port_e_out[superio_pin_mux_pkg::FAN_LINE[f]],
                   port_e_oe[superio_pin_mux_pkg::FAN_LINE[f]]}),
      .func_drive({fan_pulse_out[f], 1'b1}),
      .pad_drive(fan_pin[f]),
      .pad_in(fan_pin_in[f]),
      .port_in(fan_port_in[f]),
      .func_in()
    );
  end

  // sensor wire pin; the route bit is active low for the function
  pin_route_cell u_sensor (
    .sel(~st.cfg_b.sensor_wire_route_n),
    .port_drive({port_e_out[superio_pin_mux_pkg::SENSOR_LINE],
                 port_e_oe[superio_pin_mux_pkg::SENSOR_LINE]}),
    .func_drive(sensor_wire_drive),
    .pad_drive(sensor_pin),
    .pad_in(sensor_pin_in),
    .port_in(sensor_port_in),
    .func_in(sensor_wire_in)
  );

  // second pci reset pin; the port line's own default must suit the board
  pin_route_cell u_pci (
    .sel(~st.cfg_b.pci_reset_out_b_route_n),
    .port_drive(port_e_line_12),
    .func_drive({pci_reset_out_b, 1'b1}),
    .pad_drive(pci_reset_pin),
    .pad_in(pci_reset_pin_in),
    .port_in(port_e_line_12_in),
    .func_in()
  );

  // serial bank: per slot, pick pin, port line and owner, then scatter onto pins
  assign ser_fn_out = {ser_tx.infrared_transmit, 1'b0, 1'b0, ser_tx.terminal_ready, 1'b0,
                       ser_tx.request_to_send, 1'b0, ser_tx.serial_tx, 1'b0, 1'b0};

  always_comb begin
    slot_pin = st.cfg_a.legacy_pinout_select ? superio_pin_mux_pkg::SER_PIN_LEGACY :
                                               superio_pin_mux_pkg::SER_PIN_STD;
    slot_line = st.cfg_a.legacy_pinout_select ? superio_pin_mux_pkg::SLOT_LINE_LEGACY :
                                                superio_pin_mux_pkg::SLOT_LINE_STD;
    bank_sel = '0;
    bank_port = '0;
    bank_func = '0;
    for (int s = 0; s < superio_pin_mux_pkg::SER_PIN_COUNT; s++) begin
      slot_func_en[s] = (4'(s) >= superio_pin_mux_pkg::SER_IR_FIRST) ?
                        st.cfg_a.infrared_route : st.cfg_a.second_serial_route;
      slot_func[s] = {ser_fn_out[s], superio_pin_mux_pkg::SER_DIR_OUT[s]};
      if (slot_line[s] == superio_pin_mux_pkg::LINE_GPO12) begin
        slot_port[s] = {gpo12, 1'b1};
      end else if (slot_line[s] == superio_pin_mux_pkg::LINE_GPO13) begin
        slot_port[s] = {gpo13, 1'b1};
      end else begin
        slot_port[s] = {port_e_out[slot_line[s][2:0]], port_e_oe[slot_line[s][2:0]]};
      end
      for (int p = 0; p < superio_pin_mux_pkg::SER_PIN_COUNT; p++) begin
        if (slot_pin[s] == 4'(p)) begin
          bank_sel[p] = slot_func_en[s];
          bank_port[p] = slot_port[s];
          bank_func[p] = slot_func[s];
        end
      end
    end
  end

  for (genvar p = 0; p < superio_pin_mux_pkg::SER_PIN_COUNT; p++) begin : g_bank
    pin_route_cell u_bank (
      .sel(bank_sel[p]),
      .port_drive(bank_port[p]),
      .func_drive(bank_func[p]),
      .pad_drive(ser_pin[p]),
      .pad_in(ser_pin_in[p]),
      .port_in(bank_port_in[p]),
      .func_in(bank_func_in[p])
    );
  end

  // gather pad levels back per slot and per port line; a line on two pins reads as their OR
  always_comb begin
    port_e_in = {2'b00, fan_port_in, 2'b00, sensor_port_in};
    for (int s = 0; s < superio_pin_mux_pkg::SER_PIN_COUNT; s++) begin
      slot_port_in[s] = bank_port_in[slot_pin[s]];
      slot_func_in[s] = bank_func_in[slot_pin[s]];
      if (slot_line[s] < superio_pin_mux_pkg::LINE_GPO12) begin
        port_e_in[slot_line[s][2:0]] = port_e_in[slot_line[s][2:0]] | slot_port_in[s];
      end
    end
    ser_rx = {slot_func_in[0], slot_func_in[1], slot_func_in[3], slot_func_in[5],
              slot_func_in[7], slot_func_in[8]};
  end

  default clocking @(posedge mclk); endclocking
  default disable iff (!rstn);

  property p_fan_c_route;
    (cfg_wr && cfg_index == superio_pin_mux_pkg::CFG_A_INDEX) |=>
      (fan_pin[2].out == ($past(cfg_wdata[7]) ? fan_pulse_out[2] : port_e_out[5]));
  endproperty
  a_fan_c_route: assert property (p_fan_c_route) else $error("fan c pin not routed");

  property p_fan_b_route;
    (cfg_wr && cfg_index == superio_pin_mux_pkg::CFG_A_INDEX && cfg_wdata[6]) |=>
      (fan_pin[1].out == fan_pulse_out[1]) && fan_pin[1].oe;
  endproperty
  a_fan_b_route: assert property (p_fan_b_route) else $error("fan b pin not routed");

  property p_fan_a_port;
    !st.cfg_a.fan_pulse1_route |-> fan_pin[0] == {port_e_out[3], port_e_oe[3]};
  endproperty
  a_fan_a_port: assert property (p_fan_a_port) else $error("fan a pin lost port line");

  property p_legacy_map;
    (st.cfg_a.second_serial_route && st.cfg_a.legacy_pinout_select) |->
      (ser_pin[4].out == ser_tx.serial_tx) &&
      (!st.cfg_a.infrared_route || (ser_pin[0].out == ser_tx.infrared_transmit));
  endproperty
  a_legacy_map: assert property (p_legacy_map) else $error("legacy serial map wrong");

  property p_serial_off;
    !st.cfg_a.second_serial_route |->
      (ser_pin[st.cfg_a.legacy_pinout_select ? 4 : 2] == {gpo12, 1'b1});
  endproperty
  a_serial_off: assert property (p_serial_off) else $error("port output missing on bank");

  property p_pair_lines;
    (!st.cfg_a.second_serial_route && !st.cfg_a.legacy_pinout_select) |->
      (ser_pin[6].out == port_e_out[0]) && (ser_pin[7].out == port_e_out[2]);
  endproperty
  a_pair_lines: assert property (p_pair_lines) else $error("serial-off pair wrong");

  property p_ir_on;
    (st.cfg_a.infrared_route && !st.cfg_a.legacy_pinout_select) |->
      (ser_pin[9] == {ser_tx.infrared_transmit, 1'b1});
  endproperty
  a_ir_on: assert property (p_ir_on) else $error("infrared transmit not on pin");

  property p_ir_off_legacy;
    (!st.cfg_a.infrared_route && st.cfg_a.legacy_pinout_select) |->
      (ser_pin[0].out == port_e_out[0]) && (ser_pin[2].out == port_e_out[2]);
  endproperty
  a_ir_off_legacy: assert property (p_ir_off_legacy) else $error("ir-off lines wrong");

  property p_sensor_route;
    (cfg_wr && cfg_index == superio_pin_mux_pkg::CFG_B_INDEX && !cfg_wdata[7]) |=>
      (sensor_pin == sensor_wire_drive) && (sensor_port_in == 1'b0);
  endproperty
  a_sensor_route: assert property (p_sensor_route) else $error("sensor wire not routed");

  property p_pci_route;
    st.cfg_b.pci_reset_out_b_route_n ? (pci_reset_pin == port_e_line_12) :
                                       (pci_reset_pin == {pci_reset_out_b, 1'b1});
  endproperty
  a_pci_route: assert property (p_pci_route) else $error("pci reset pin wrong");

  property p_strap_hold;
    (main_supply_good && !st.supply_good_q) ##1 (st.supply_good_q [*3]) |->
      st.cfg_b.main_supply_strap_b == $past(main_supply_strap_b, 3);
  endproperty
  a_strap_hold: assert property (p_strap_hold) else $error("strap not held");

  property p_read_back;
    (cfg_rd && cfg_index == superio_pin_mux_pkg::CFG_B_INDEX && !cfg_wr) |=>
      cfg_rvalid && (cfg_rdata[0] == st.cfg_b.main_supply_strap_b) && (cfg_rdata[5] == 1'b0);
  endproperty
  a_read_back: assert property (p_read_back) else $error("config b read wrong");

endmodule // superio_pin_function_mux

`default_nettype wire

// ---- dv/superio_pin_function_mux_test.sv ----
`timescale 1ns/1ns
`default_nettype none

module superio_pin_function_mux_test;
  // stimulus and observed signals
  logic mclk, rstn, cfg_wr, cfg_rd, cfg_rvalid, main_supply_good, main_supply_strap_b;
  logic [7:0] cfg_index, cfg_wdata, cfg_rdata, port_e_out, port_e_oe, port_e_in;
  logic tach_pin_enable, sensor_wire_in, pci_reset_out_b, gpo12, gpo13, port_e_line_12_in;
  logic sensor_pin_in, pci_reset_pin_in;
  logic [2:0] fan_pulse_out, fan_pin_in;
  logic [9:0] ser_pin_in;
  superio_pin_mux_pkg::pin_drive_t sensor_wire_drive, port_e_line_12, sensor_pin, pci_reset_pin;
  superio_pin_mux_pkg::pin_drive_t [2:0] fan_pin;
  superio_pin_mux_pkg::pin_drive_t [9:0] ser_pin;
  superio_pin_mux_pkg::ser_tx_t ser_tx;
  superio_pin_mux_pkg::ser_rx_t ser_rx;
  int error_cnt = 0;
  int check_count = 0;
  int cycles = 0;
  // bank pin of each function slot in the standard and legacy pinouts
  int pin_std[10] = '{0, 1, 2, 3, 4, 5, 6, 7, 8, 9};
  int pin_leg[10] = '{1, 3, 4, 5, 6, 7, 8, 9, 2, 0};
  // port line per slot when unrouted; 8 and 9 stand for the two output-only lines
  int line_std[10] = '{1, 3, 8, 4, 9, 5, 0, 2, 6, 7};
  int line_leg[10] = '{1, 3, 8, 4, 9, 5, 6, 7, 2, 0};
  int in_slot[6] = '{0, 1, 3, 5, 7, 8};
  int out_slot[4] = '{2, 4, 6, 9};

  superio_pin_function_mux dut_u (
    .mclk(mclk), .rstn(rstn), .cfg_index(cfg_index), .cfg_wdata(cfg_wdata),
    .cfg_wr(cfg_wr), .cfg_rd(cfg_rd), .cfg_rdata(cfg_rdata), .cfg_rvalid(cfg_rvalid),
    .main_supply_good(main_supply_good), .main_supply_strap_b(main_supply_strap_b),
    .tach_pin_enable(tach_pin_enable), .fan_pulse_out(fan_pulse_out),
    .sensor_wire_drive(sensor_wire_drive), .sensor_wire_in(sensor_wire_in),
    .pci_reset_out_b(pci_reset_out_b), .ser_tx(ser_tx), .ser_rx(ser_rx),
    .port_e_out(port_e_out), .port_e_oe(port_e_oe), .port_e_in(port_e_in),
    .gpo12(gpo12), .gpo13(gpo13), .port_e_line_12(port_e_line_12),
    .port_e_line_12_in(port_e_line_12_in), .fan_pin(fan_pin), .fan_pin_in(fan_pin_in),
    .sensor_pin(sensor_pin), .sensor_pin_in(sensor_pin_in), .pci_reset_pin(pci_reset_pin),
    .pci_reset_pin_in(pci_reset_pin_in), .ser_pin(ser_pin), .ser_pin_in(ser_pin_in)
  );

  // free-running 100 MHz clock
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  // hang guard: the whole sequence needs well under a thousand cycles
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 5000) begin
      error_cnt++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, cycles, 0);
      final_report();
    end
  end

  task automatic final_report;
    $display("checks=%0d mismatches=%0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // write strobe lasts one cycle; on return the taking edge has passed
  task automatic wr(input logic [7:0] idx, input logic [7:0] data);
    @(negedge mclk);
    cfg_index = idx;
    cfg_wdata = data;
    cfg_wr = 1'b1;
    @(negedge mclk);
    cfg_wr = 1'b0;
  endtask

  // answer is a one-cycle pulse, so it is looked at in the very next cycle
  task automatic rd_chk(input logic [7:0] idx, input logic [7:0] exp);
    @(negedge mclk);
    cfg_index = idx;
    cfg_rd = 1'b1;
    @(negedge mclk);
    cfg_rd = 1'b0;
    chk({7'h0, cfg_rvalid}, 8'h01);
    chk(cfg_rdata, exp);
  endtask

  task automatic test_reset;
    rd_chk(8'h23, 8'h00);
    rd_chk(8'h24, 8'h00);
    for (int k = 0; k < 3; k++) begin
      chk({6'h0, fan_pin[k]}, {6'h0, port_e_out[3+k], port_e_oe[3+k]});
    end
    chk({6'h0, sensor_pin}, {6'h0, sensor_wire_drive});
    chk({7'h0, pci_reset_pin.out}, {7'h0, pci_reset_out_b});
    // strap is caught when the main supply comes up, then held
    @(negedge mclk);
    main_supply_good = 1'b1;
    repeat (2) @(negedge mclk);
    main_supply_strap_b = 1'b0;
    rd_chk(8'h24, 8'h01);
    $display("test_reset done");
  endtask

  task automatic test_fan;
    wr(8'h23, 8'hFF);
    for (int k = 0; k < 3; k++) begin
      chk({6'h0, fan_pin[k]}, {6'h0, fan_pulse_out[k], 1'b1});
    end
    rd_chk(8'h23, 8'hE7);
    wr(8'h23, 8'h40);
    for (int k = 0; k < 3; k++) begin
      chk({6'h0, fan_pin[k]}, (k == 1) ? {6'h0, fan_pulse_out[1], 1'b1} :
          {6'h0, port_e_out[3+k], port_e_oe[3+k]});
    end
    // fan pad levels reach the port only on pins the port still owns
    fan_pin_in = 3'b111;
    #1;
    chk(port_e_in, 8'h28);
    fan_pin_in = 3'b000;
    $display("test_fan done");
  endtask

  task automatic test_bank(input logic legacy);
    int pin;
    wr(8'h23, {5'h0, legacy, 2'b11});
    for (int i = 0; i < 6; i++) begin
      pin = legacy ? pin_leg[in_slot[i]] : pin_std[in_slot[i]];
      @(negedge mclk);
      ser_pin_in = 10'h001 << pin;
      #1;
      chk({2'h0, ser_rx}, 8'h20 >> i);
      chk({7'h0, ser_pin[pin].oe}, 8'h00);
    end
    for (int j = 0; j < 4; j++) begin
      pin = legacy ? pin_leg[out_slot[j]] : pin_std[out_slot[j]];
      @(negedge mclk);
      ser_tx = 4'h8 >> j;
      #1;
      chk({6'h0, ser_pin[pin]}, 8'h03);
    end
    $display("test_bank done");
  endtask

  task automatic test_gpio_bank(input logic legacy);
    int pin;
    int line;
    wr(8'h23, {5'h0, legacy, 2'b00});
    for (int s = 0; s < 10; s++) begin
      pin = legacy ? pin_leg[s] : pin_std[s];
      line = legacy ? line_leg[s] : line_std[s];
      @(negedge mclk);
      gpo12 = (line == 8);
      gpo13 = (line == 9);
      port_e_out = (line < 8) ? (8'h01 << line) : 8'h00;
      ser_pin_in = 10'h001 << pin;
      #1;
      chk({6'h0, ser_pin[pin]}, 8'h03);
      if (line < 8) begin
        chk(port_e_in, 8'h01 << line);
      end
    end
    $display("test_gpio_bank done");
  endtask

  // serial and infrared selections act independently, in both pinouts
  task automatic test_split;
    wr(8'h23, 8'h02);
    ser_tx = 4'h8;
    port_e_out = 8'h80;
    #1;
    chk({6'h0, ser_pin[2]}, 8'h03);
    chk({6'h0, ser_pin[9]}, 8'h03);
    wr(8'h23, 8'h06);
    ser_tx = 4'h1;
    port_e_out = 8'h00;
    gpo12 = 1'b1;
    #1;
    chk({6'h0, ser_pin[4]}, 8'h01);
    chk({6'h0, ser_pin[0]}, 8'h01);
    wr(8'h23, 8'h05);
    #1;
    chk({6'h0, ser_pin[4]}, 8'h03);
    chk({6'h0, ser_pin[0]}, 8'h03);
    $display("test_split done");
  endtask

  task automatic test_cfg_b;
    @(negedge mclk);
    sensor_pin_in = 1'b1;
    pci_reset_pin_in = 1'b1;
    port_e_out = 8'h01;
    #1;
    chk({7'h0, sensor_wire_in}, 8'h01);
    chk({7'h0, port_e_line_12_in}, 8'h00);
    // port line 12 idles as an enabled low drive, which this board tolerates
    wr(8'h24, 8'h90);
    chk({6'h0, sensor_pin}, {6'h0, port_e_out[0], port_e_oe[0]});
    chk({7'h0, sensor_wire_in}, 8'h00);
    chk({6'h0, pci_reset_pin}, {6'h0, port_e_line_12});
    chk({7'h0, port_e_line_12_in}, 8'h01);
    rd_chk(8'h24, 8'h91);
    wr(8'h24, 8'hFF);
    rd_chk(8'h24, 8'hD1);
    chk({7'h0, tach_pin_enable}, 8'h01);
    wr(8'h24, 8'h00);
    chk({7'h0, tach_pin_enable}, 8'h00);
    chk({7'h0, pci_reset_pin.out}, {7'h0, pci_reset_out_b});
    rd_chk(8'h25, 8'h00);
    $display("test_cfg_b done");
  endtask

  // main sequence
  initial begin
    rstn = 1'b0;
    {cfg_wr, cfg_rd, main_supply_good, gpo12, gpo13} = 5'h0;
    cfg_index = 8'h00;
    cfg_wdata = 8'h00;
    main_supply_strap_b = 1'b1;
    fan_pulse_out = 3'b010;
    fan_pin_in = 3'b000;
    sensor_wire_drive = 2'b10;
    port_e_line_12 = 2'b01;
    pci_reset_out_b = 1'b1;
    ser_tx = 4'h0;
    port_e_out = 8'h28;
    port_e_oe = 8'hFF;
    sensor_pin_in = 1'b0;
    pci_reset_pin_in = 1'b0;
    ser_pin_in = 10'h000;
    repeat (10) @(posedge mclk);
    @(negedge mclk);
    rstn = 1'b1;
    test_reset();
    test_fan();
    test_bank(1'b0);
    test_bank(1'b1);
    test_gpio_bank(1'b0);
    test_gpio_bank(1'b1);
    test_split();
    test_cfg_b();
    final_report();
  end
endmodule // superio_pin_function_mux_test

`default_nettype wire
